// File: rtl/errlog_pkg.sv
package errlog_pkg;

  // Geometry
  localparam int unsigned NUM_TARGETS_DEF = 14;
  localparam int unsigned MAX_TARGETS     = 16;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned TGT_W           = 4;
  localparam int unsigned ID_W            = 8;
  localparam int unsigned CODE_W          = 4;
  localparam int unsigned AREA_W          = 4;
  localparam int unsigned CMD_W           = 3;
  localparam int unsigned SRC_W           = 4;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] LOG_BASE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] LOG_STRIDE   = 8'h04;
  localparam logic [ADDR_W-1:0] SYS_CFG_OFS  = 8'h40;

  // Error log field positions
  localparam int unsigned MULTI_BIT = 31;
  localparam int unsigned CODE_LSB  = 24;
  localparam int unsigned ID_LSB    = 8;
  localparam int unsigned AREA_LSB  = 4;
  localparam int unsigned CMD_LSB   = 0;

  // System config field positions
  localparam int unsigned DMA_PRI_BIT = 25;
  localparam int unsigned CPU_PRI_BIT = 24;

  // Reset values
  localparam logic [DATA_W-1:0] LOG_RESET     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SYS_CFG_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 32'h0000_0000;

  // Error kinds
  localparam logic [CODE_W-1:0] CODE_NONE      = 4'h0;
  localparam logic [CODE_W-1:0] CODE_PERM_VIOL = 4'h3;

  // Requester identifiers
  localparam logic [ID_W-1:0] ID_RESERVED  = 8'h00;
  localparam logic [ID_W-1:0] ID_CPU_LO    = 8'h01;
  localparam logic [ID_W-1:0] ID_CPU_HI    = 8'h02;
  localparam logic [ID_W-1:0] ID_DMA_RD_LO = 8'h03;
  localparam logic [ID_W-1:0] ID_DMA_RD_HI = 8'h04;
  localparam logic [ID_W-1:0] ID_DMA_WR_LO = 8'h05;
  localparam logic [ID_W-1:0] ID_DMA_WR_HI = 8'h06;
  localparam logic [ID_W-1:0] ID_USB       = 8'h07;
  localparam logic [ID_W-1:0] ID_NET_RD    = 8'h08;
  localparam logic [ID_W-1:0] ID_NET_WR    = 8'h09;
  localparam logic [ID_W-1:0] ID_CAN_A     = 8'h0A;
  localparam logic [ID_W-1:0] ID_CAN_B     = 8'h0B;
  localparam logic [ID_W-1:0] ID_SERMEM    = 8'h0C;
  localparam logic [ID_W-1:0] ID_FLASH     = 8'h0D;
  localparam logic [ID_W-1:0] ID_CRYPTO    = 8'h0E;

  // Initiator classes presented by the permission checker
  typedef enum logic [SRC_W-1:0] {
    SRC_CPU    = 4'h0,
    SRC_DMA_RD = 4'h1,
    SRC_DMA_WR = 4'h2,
    SRC_USB    = 4'h3,
    SRC_NET_RD = 4'h4,
    SRC_NET_WR = 4'h5,
    SRC_CAN_A  = 4'h6,
    SRC_CAN_B  = 4'h7,
    SRC_SERMEM = 4'h8,
    SRC_FLASH  = 4'h9,
    SRC_CRYPTO = 4'hA
  } source_t;

endpackage

// File: rtl/error_log_entry.sv
`timescale 1ns/1ps
`default_nettype none

module error_log_entry
  import errlog_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_viol,
  input  wire logic [ID_W-1:0]   i_req_id,
  input  wire logic [AREA_W-1:0] i_area,
  input  wire logic [CMD_W-1:0]  i_cmd,
  input  wire logic              i_wr,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0]      o_value,
  output logic                   o_pending
);

  logic              multi_q,  multi_d;
  logic [CODE_W-1:0] code_q,   code_d;
  logic [ID_W-1:0]   req_id_q, req_id_d;
  logic [AREA_W-1:0] area_q,   area_d;
  logic [CMD_W-1:0]  cmd_q,    cmd_d;

  always_comb begin
    multi_d  = multi_q;
    code_d   = code_q;
    req_id_d = req_id_q;
    area_d   = area_q;
    cmd_d    = cmd_q;
    if (i_wr) begin
      if (i_wdata[MULTI_BIT]) begin
        multi_d = 1'b0; // RULE3
      end
      code_d = code_q & ~i_wdata[CODE_LSB +: CODE_W]; // RULE6
    end
    // Set wins over a clear in the same cycle
    if (i_viol) begin
      if (code_q != CODE_NONE) begin
        multi_d = 1'b1; // RULE2
      end else begin
        // First violation owns the captured fields
        req_id_d = i_req_id; // RULE7
        area_d   = i_area; // RULE12
        cmd_d    = i_cmd; // RULE12
      end
      code_d = CODE_PERM_VIOL; // RULE5
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      multi_q  <= LOG_RESET[MULTI_BIT];
      code_q   <= LOG_RESET[CODE_LSB +: CODE_W];
      req_id_q <= LOG_RESET[ID_LSB +: ID_W];
      area_q   <= LOG_RESET[AREA_LSB +: AREA_W];
      cmd_q    <= LOG_RESET[CMD_LSB +: CMD_W];
    end else begin
      multi_q  <= multi_d;
      code_q   <= code_d;
      req_id_q <= req_id_d;
      area_q   <= area_d;
      cmd_q    <= cmd_d;
    end
  end

  // Unimplemented bits read zero
  always_comb begin
    o_value                      = '0; // RULE11
    o_value[MULTI_BIT]           = multi_q;
    o_value[CODE_LSB +: CODE_W]  = code_q; // RULE4
    o_value[ID_LSB +: ID_W]      = req_id_q;
    o_value[AREA_LSB +: AREA_W]  = area_q;
    o_value[CMD_LSB +: CMD_W]    = cmd_q;
  end

  assign o_pending = (code_q != CODE_NONE);

endmodule // error_log_entry

`default_nettype wire

// File: rtl/bus_target_error_log.sv
// Functional notes
// RULE1: One error log register of this layout exists per bus target, targets 0 to 13.
// RULE2: Bit 31 is set once more than one violation has hit this target, else clear.
// RULE3: Writing one to bit 31 clears it; writing zero leaves it alone.
// RULE4: Bits 27..24 give the error kind, 0000 meaning none, unlisted values reserved.
// RULE5: A permission violation loads the error kind with 0011.
// RULE6: Writing ones into the error kind clears those bits.
// RULE7: Bits 15..8 hold the read-only 8-bit identifier of the offending requester.
// RULE8: Identifiers: USB 07, net read 08, net write 09, CAN 0A and 0B, flash 0D, crypto 0E.
// RULE9: DMA read is 03 or 04 and DMA write 05 or 06, per the DMA priority select bit.
// RULE10: The processor is 01 or 02, per the processor priority select bit.
// RULE11: Bits 23..16 and 30..28 read zero and ignore writes.
// RULE12: Bits 7..4 capture the target area, bits 2..0 the bus command, bit 3 reads zero.
`timescale 1ns/1ps
`default_nettype none

module bus_target_error_log
  import errlog_pkg::*;
#(
  parameter int unsigned NUM_TARGETS = NUM_TARGETS_DEF
)(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_ARST_N,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic [DATA_W-1:0]      O_RDATA,
  input  wire logic              I_VIOL,
  input  wire logic [TGT_W-1:0]  I_VIOL_TARGET,
  input  wire logic [SRC_W-1:0]  I_VIOL_SOURCE,
  input  wire logic [AREA_W-1:0] I_VIOL_AREA,
  input  wire logic [CMD_W-1:0]  I_VIOL_CMD,
  output logic [NUM_TARGETS-1:0] O_ERR_PENDING,
  output logic                   O_DMA_PRIORITY_SELECT,
  output logic                   O_PROCESSOR_PRIORITY_SELECT
);

  // Address decode only reaches 16 log slots
  if (NUM_TARGETS < 1 || NUM_TARGETS > MAX_TARGETS) begin : g_bad_targets
    $error("NUM_TARGETS must lie in 1..16");
  end

  // Byte address of one target's log word
  function automatic logic [ADDR_W-1:0] log_addr(input int unsigned idx);
    log_addr = LOG_BASE_OFS + LOG_STRIDE * idx[ADDR_W-1:0];
  endfunction

  // Requester identifier from class and priority selects
  function automatic logic [ID_W-1:0] encode_source(input logic [SRC_W-1:0] src,
                                                    input logic dma_pri,
                                                    input logic cpu_pri);
    case (src)
      SRC_CPU:    encode_source = cpu_pri ? ID_CPU_HI : ID_CPU_LO; // RULE10
      SRC_DMA_RD: encode_source = dma_pri ? ID_DMA_RD_HI : ID_DMA_RD_LO; // RULE9
      SRC_DMA_WR: encode_source = dma_pri ? ID_DMA_WR_HI : ID_DMA_WR_LO; // RULE9
      SRC_USB:    encode_source = ID_USB; // RULE8
      SRC_NET_RD: encode_source = ID_NET_RD; // RULE8
      SRC_NET_WR: encode_source = ID_NET_WR; // RULE8
      SRC_CAN_A:  encode_source = ID_CAN_A; // RULE8
      SRC_CAN_B:  encode_source = ID_CAN_B; // RULE8
      SRC_SERMEM: encode_source = ID_SERMEM;
      SRC_FLASH:  encode_source = ID_FLASH; // RULE8
      SRC_CRYPTO: encode_source = ID_CRYPTO; // RULE8
      // Unknown class logs the reserved code rather than a real initiator
      default:    encode_source = ID_RESERVED;
    endcase
  endfunction

  logic [DATA_W-1:0]     sys_cfg_q, sys_cfg_d;
  logic [DATA_W-1:0]     rdata_q,   rdata_d;
  logic [ID_W-1:0]       viol_id;
  logic [DATA_W-1:0]     log_value [NUM_TARGETS];
  logic [NUM_TARGETS-1:0] log_wr;
  logic [NUM_TARGETS-1:0] log_viol;

  assign O_DMA_PRIORITY_SELECT       = sys_cfg_q[DMA_PRI_BIT];
  assign O_PROCESSOR_PRIORITY_SELECT = sys_cfg_q[CPU_PRI_BIT];

  // Selects take effect on the violation cycle itself
  assign viol_id = encode_source(I_VIOL_SOURCE, sys_cfg_q[DMA_PRI_BIT], sys_cfg_q[CPU_PRI_BIT]);

  for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_log
    assign log_wr[t]   = I_WR && (I_ADDR == log_addr(t));
    assign log_viol[t] = I_VIOL && (I_VIOL_TARGET == TGT_W'(t)); // RULE1

    error_log_entry u_entry (
      .i_clk     (I_CLK_SYS),
      .i_arst_n  (I_ARST_N),
      .i_viol    (log_viol[t]),
      .i_req_id  (viol_id),
      .i_area    (I_VIOL_AREA),
      .i_cmd     (I_VIOL_CMD),
      .i_wr      (log_wr[t]),
      .i_wdata   (I_WDATA),
      .o_value   (log_value[t]),
      .o_pending (O_ERR_PENDING[t])
    );
  end

  // Only the two select bits are implemented in the config word
  always_comb begin
    sys_cfg_d = sys_cfg_q;
    if (I_WR && I_ADDR == SYS_CFG_OFS) begin
      sys_cfg_d                 = '0;
      sys_cfg_d[DMA_PRI_BIT]    = I_WDATA[DMA_PRI_BIT];
      sys_cfg_d[CPU_PRI_BIT]    = I_WDATA[CPU_PRI_BIT];
    end
  end

  // Read data lands one cycle after the strobe and only then
  always_comb begin
    rdata_d = RDATA_UNMAPPED;
    if (I_RD) begin
      if (I_ADDR == SYS_CFG_OFS) begin
        rdata_d = sys_cfg_q;
      end else begin
        for (int unsigned t = 0; t < NUM_TARGETS; t++) begin
          if (I_ADDR == log_addr(t)) begin
            rdata_d = log_value[t];
          end
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sys_cfg_q <= SYS_CFG_RESET;
      rdata_q   <= RDATA_UNMAPPED;
    end else begin
      sys_cfg_q <= sys_cfg_d;
      rdata_q   <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;

endmodule // bus_target_error_log

`default_nettype wire

// File: tb/errlog_sva.sv
`timescale 1ns/1ps
`default_nettype none
module errlog_sva #(
  parameter int unsigned NUM_TARGETS = 14
)(
  input wire logic                   I_CLK_SYS,
  input wire logic                   I_ARST_N,
  input wire logic [7:0]             I_ADDR,
  input wire logic [31:0]            I_WDATA,
  input wire logic                   I_WR,
  input wire logic                   I_RD,
  input wire logic [31:0]            O_RDATA,
  input wire logic                   I_VIOL,
  input wire logic [3:0]             I_VIOL_TARGET,
  input wire logic [NUM_TARGETS-1:0] O_ERR_PENDING,
  input wire logic                   O_DMA_PRIORITY_SELECT,
  input wire logic                   O_PROCESSOR_PRIORITY_SELECT
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  sequence s_viol;
    I_VIOL && I_VIOL_TARGET < 4'hE;
  endsequence
  // One quiet cycle, then a read of the logged target
  sequence s_rd_back;
    !I_WR ##1 I_RD && I_ADDR == {2'b00, $past(I_VIOL_TARGET, 2), 2'b00};
  endsequence
  rd_idle_a: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("read data not zero outside read slot");
  unimpl_bits_a: assert property (
    I_RD |=> O_RDATA[30:28] == 3'h0 && O_RDATA[23:16] == 8'h0 && !O_RDATA[3])
    else $error("unimplemented bit read as one");
  viol_pend_a: assert property (s_viol |=> O_ERR_PENDING[$past(I_VIOL_TARGET)])
    else $error("pending not raised by violation");
  pend_hold_a: assert property (!I_WR && !I_VIOL |=> $stable(O_ERR_PENDING))
    else $error("pending changed without cause");
  sel_hold_a: assert property (
    !(I_WR && I_ADDR == 8'h40) |=> $stable({O_DMA_PRIORITY_SELECT, O_PROCESSOR_PRIORITY_SELECT}))
    else $error("priority select changed without write");
  cfg_read_a: assert property (I_RD && I_ADDR == 8'h40 |=>
    O_RDATA == {6'h00, O_DMA_PRIORITY_SELECT, O_PROCESSOR_PRIORITY_SELECT, 24'h0})
    else $error("config readback wrong");
  viol_code_a: assert property (s_viol ##1 s_rd_back |=> O_RDATA[27:24] == 4'h3)
    else $error("error kind not permission violation");
  multi_clr_a: assert property (I_WR && I_WDATA[31] && !I_VIOL && I_ADDR < 8'h38
    ##1 !I_VIOL && !I_WR ##1 !I_VIOL && I_RD && I_ADDR == $past(I_ADDR, 2) |=> !O_RDATA[31])
    else $error("multiple flag not cleared");
endmodule // errlog_sva
bind bus_target_error_log errlog_sva #(.NUM_TARGETS(NUM_TARGETS)) u_sva (.I_CLK_SYS, .I_ARST_N,
  .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_VIOL, .I_VIOL_TARGET, .O_ERR_PENDING,
  .O_DMA_PRIORITY_SELECT, .O_PROCESSOR_PRIORITY_SELECT);
`default_nettype wire

// File: tb/viol_source.sv
`timescale 1ns/1ps
`default_nettype none
module viol_source (
  input  wire logic       i_clk,
  output logic            o_viol,
  output logic [3:0]      o_tgt,
  output logic [3:0]      o_src,
  output logic [3:0]      o_area,
  output logic [2:0]      o_cmd
);
  initial {o_viol, o_tgt, o_src, o_area, o_cmd} = '0;
  // Released fields flip so stale values are never mistaken for live ones
  task automatic fire(input logic [3:0] t, s, a, input logic [2:0] c, input int n);
    @(posedge i_clk);
    {o_viol, o_tgt, o_src, o_area, o_cmd} <= {1'b1, t, s, a, c};
    repeat (n) @(posedge i_clk);
    {o_viol, o_tgt, o_src, o_area, o_cmd} <= {1'b0, ~t, ~s, ~a, ~c};
    // Let the captured log settle before the caller looks
    #1;
  endtask
endmodule // viol_source
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, arst_n, wr, rd, viol, dsel, psel;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  tgt, src, area;
  logic [2:0]  cmd;
  logic [13:0] pend;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [7:0]  id_tab [11] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
                                8'h0C, 8'h0D, 8'h0E};
  bus_target_error_log #(.NUM_TARGETS(14)) DUT (.I_CLK_SYS(clk), .I_ARST_N(arst_n),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_VIOL(viol),
    .I_VIOL_TARGET(tgt), .I_VIOL_SOURCE(src), .I_VIOL_AREA(area), .I_VIOL_CMD(cmd),
    .O_ERR_PENDING(pend), .O_DMA_PRIORITY_SELECT(dsel), .O_PROCESSOR_PRIORITY_SELECT(psel));
  viol_source u_src (.i_clk(clk), .o_viol(viol), .o_tgt(tgt), .o_src(src), .o_area(area),
    .o_cmd(cmd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
    // Registers update on this edge; look after they settle
    #1;
  endtask
  // Data stands only in the slot after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic s_reset;
    logic [31:0] d;
    for (int t = 0; t < 15; t++) begin
      rd_reg(t == 14 ? 8'h40 : 8'(4 * t), d);
      chk("reset value", 32'h0, d);
    end
    chk("pending", 32'h0, pend);
  endtask
  task automatic s_ids;
    logic [31:0] d;
    logic [7:0]  id;
    for (int p = 0; p < 2; p++) begin
      wr_reg(8'h40, {6'h00, p[0], p[0], 24'h0});
      chk("selects", {30'h0, p[0], p[0]}, {dsel, psel});
      for (int s = 0; s < 11; s++) begin
        id = id_tab[s] + 8'((s < 3) && p[0]);
        u_src.fire(s[3:0], s[3:0], 4'(15 - s), 3'(s), 1);
        chk("pending", 32'h1 << s, pend);
        rd_reg(8'(4 * s), d);
        chk("log", {8'h03, 8'h00, id, 4'(15 - s), 1'b0, 3'(s)}, d);
        wr_reg(8'(4 * s), 32'h8F00_0000);
        rd_reg(8'(4 * s), d);
        chk("cleared", {16'h0, id, 4'(15 - s), 1'b0, 3'(s)}, d);
      end
    end
  endtask
  task automatic s_multi;
    logic [31:0] d;
    u_src.fire(4'hD, 4'h3, 4'h5, 3'h6, 2);
    u_src.fire(4'hD, 4'hA, 4'h1, 3'h1, 1);
    rd_reg(8'h34, d);
    chk("multi", 32'h8300_0756, d);
    wr_reg(8'h34, 32'h70FF_FFFF);
    rd_reg(8'h34, d);
    chk("zero write", 32'h8300_0756, d);
    wr_reg(8'h34, 32'h8100_0000);
    rd_reg(8'h34, d);
    chk("partial", 32'h0200_0756, d);
    u_src.fire(4'hE, 4'h0, 4'h0, 3'h0, 1);
    chk("pending", 32'h2000, pend);
    rd_reg(8'h38, d);
    chk("unmapped", 32'h0, d);
  endtask
  // Set beats a clear landing on the same edge
  task automatic s_race;
    logic [31:0] d;
    fork
      u_src.fire(4'hD, 4'h0, 4'h9, 3'h2, 1);
      wr_reg(8'h34, 32'h8F00_0000);
    join
    rd_reg(8'h34, d);
    chk("set over clear", 32'h8300_0756, d);
  endtask
  task automatic s_rst_mid;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    s_reset();
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {arst_n, addr, wdata, wr, rd} = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    s_reset();
    s_ids();
    s_multi();
    s_race();
    s_rst_mid();
    results();
  end
endmodule // tb_top
`default_nettype wire
